// ===== rtl/sfe_pkg.sv
// constants, opcodes and state types shared by both ends of the flash link
// assumes both ends run on a 25 MHz system clock (40 ns period)
// Overview of operation
// - 20h erases addressed 4KB sector to ones
// - erase accepted only with unlock latch set
// - addressed erase: opcode plus three address bytes
// - select rises exactly after 32nd bit, else discarded
// - busy flag high through self-timed cycle
// - unlock latch cleared before erase cycle ends
// - protected regions are never erased
// - 52h erases containing 32KB half block
// - D8h erases containing 64KB block
// - C7h and 60h both erase whole array
// - chip erase and sleep need exactly eight bits
// - chip erase only when protect bits zero
// - B9h enters sleep, ignoring write commands
// - deselect while idle gives ordinary standby
// - sleep ignores everything except wake command
// - sleep entered only after entry delay
// - sleep rejected during a running cycle
// - power-on always comes up in standby
// - wake-only: ABh, then hold deselect wake delay
// - ABh plus dummies shifts id repeatedly
// - wake with id takes wake id delay
// - wake command ignored during running cycle
package sfe_pkg;

  // opcodes
  localparam logic [7:0] OP_UNIT4K_WIPE  = 8'h20;
  localparam logic [7:0] OP_HALF_WIPE    = 8'h52;
  localparam logic [7:0] OP_FULL_WIPE    = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE_A  = 8'hc7;
  localparam logic [7:0] OP_CHIP_WIPE_B  = 8'h60;
  localparam logic [7:0] OP_SLEEP        = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID      = 8'hab;
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;

  // frame lengths in bits
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDRED = 6'h20;

  // region masks (byte address bits cleared for base)
  localparam logic [23:0] MASK_4K  = 24'h000fff;
  localparam logic [23:0] MASK_32K = 24'h007fff;
  localparam logic [23:0] MASK_64K = 24'h00ffff;
  localparam logic [23:0] MASK_ALL = 24'hffffff;

  // timing, ns and derived cycles (least times, rounded up)
  localparam int CLK_NS         = 40;
  localparam int T_SLEEP_NS     = 3000;
  localparam int T_WAKE_NS      = 3000;
  localparam int T_WAKE_ID_NS   = 1800;
  localparam int SLEEP_CYC      = (T_SLEEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYC       = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_ID_CYC    = (T_WAKE_ID_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_SLACK_CYC = 4;

  // host serial clock and register map
  localparam int         HALF_CYC     = 4;
  localparam logic [1:0] REG_CMD      = 2'h0;
  localparam logic [1:0] REG_ADDR     = 2'h1;
  localparam logic [1:0] REG_STATUS   = 2'h2;
  localparam logic [7:0] RESET_ID     = 8'h00;

  typedef enum logic [4:0] {
    DS_STANDBY = 5'b00001,
    DS_ERASE   = 5'b00010,
    DS_SLP_DLY = 5'b00100,
    DS_SLEEP   = 5'b01000,
    DS_WAKE    = 5'b10000
  } sfe_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_SHIFT = 3'b010,
    HS_GAP   = 3'b100
  } sfe_host_state_t;

endpackage

// ===== rtl/sfe_link_if.sv
// serial link between host controller and flash device end
// assumes the bench ties both modports together; no clock inside
`timescale 1ns/1ns
`default_nettype none
interface sfe_link_if;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic miso;

  modport dev  (input sel_n, input sclk, input mosi, output miso);
  modport host (output sel_n, output sclk, output mosi, input miso);
endinterface
`default_nettype wire

// ===== rtl/sfe_flash_dev.sv
// flash device end: erase, sleep and wake/id command logic
// assumes link pins are asynchronous to CLK_I; the array itself lives
// outside and acts on the wipe strobe with its address range
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module sfe_flash_dev
  #(
    parameter int UNIT4K_CYC = 1000,
    parameter int HALF_CYC_E = 2000,
    parameter int FULL_CYC   = 3000,
    parameter int CHIP_CYC   = 4000,
    parameter logic [7:0] DEVICE_ID = 8'h5a  // arbitrary value
  )
  (
    // clock and reset
    input  wire logic         CLK_I,
    input  wire logic         RST_N_I,
    // serial link
    sfe_link_if.dev           LINK,
    // protection setting, same clock domain
    input  wire logic [3:0]   PROT_I,
    // array erase request
    output logic              WIPE_STB_O,
    output logic [23:0]       WIPE_LO_O,
    output logic [23:0]       WIPE_HI_O,
    // status
    output logic              BUSY_O,
    output logic              UNLOCK_O,
    output logic              SLEEP_O,
    output logic              STANDBY_O
  );
  import sfe_pkg::*;

  logic [2:0]     sel_sync_reg;
  logic [2:0]     clk_sync_reg;
  logic [1:0]     mosi_sync_reg;
  logic           sclk_rise;
  logic           sclk_fall;
  logic           sel_rise;
  logic           sel_low;
  logic [5:0]     bcnt_reg;
  logic [7:0]     op_reg;
  logic [23:0]    addr_reg;
  logic [2:0]     id_idx_reg;
  logic           miso_reg;
  sfe_dev_state_t state_reg;
  logic [19:0]    tmr_reg;
  logic           unlock_reg;
  logic           wipe_stb_reg;
  logic [23:0]    wipe_lo_reg;
  logic [23:0]    wipe_hi_reg;
  logic           addr_ok;
  logic           op_ok;
  logic [23:0]    mask;
  logic [19:0]    dur;
  logic           is_addr_wipe;
  logic           is_chip_wipe;

  // highest address inside a protected region: top prot/16 of the space
  function automatic logic is_protected(input logic [23:0] hi, input logic [3:0] prot);
    is_protected = (prot != 4'h0) && ({1'b0, hi[23:20]} >= (5'h10 - {1'b0, prot}));
  endfunction

  // two-flop synchronisers, third stage only for edge detection
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sel_sync_reg  <= 3'h7;
      clk_sync_reg  <= 3'h0;
      mosi_sync_reg <= 2'h0;
    end
    else
    begin
      sel_sync_reg  <= {sel_sync_reg[1:0], LINK.sel_n};
      clk_sync_reg  <= {clk_sync_reg[1:0], LINK.sclk};
      mosi_sync_reg <= {mosi_sync_reg[0], LINK.mosi};
    end
  end

  assign sclk_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign sclk_fall = ~clk_sync_reg[1] & clk_sync_reg[2];
  assign sel_rise  = sel_sync_reg[1] & ~sel_sync_reg[2];
  assign sel_low   = ~sel_sync_reg[1];

  // input shifter: opcode then address, bit count saturates
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      bcnt_reg <= 6'h00;
      op_reg   <= 8'h00;
      addr_reg <= 24'h000000;
    end
    else if (!sel_low)
      bcnt_reg <= 6'h00;
    else if (sclk_rise)
    begin
      if (bcnt_reg != 6'h3f)
        bcnt_reg <= bcnt_reg + 6'h01;
      if (bcnt_reg < BITS_OPCODE)
        op_reg <= {op_reg[6:0], mosi_sync_reg[1]};
      else if (bcnt_reg < BITS_ADDRED)
        addr_reg <= {addr_reg[22:0], mosi_sync_reg[1]};
    end
  end

  // id shifter: after opcode and three dummies, msb first on falling edges
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      id_idx_reg <= 3'h7;
      miso_reg   <= 1'b0;
    end
    else if (!sel_low)
    begin
      id_idx_reg <= 3'h7;
      miso_reg   <= 1'b0;
    end
    else if (sclk_fall && bcnt_reg >= BITS_ADDRED && op_reg == OP_WAKE_ID
             && (state_reg == DS_STANDBY || state_reg == DS_SLEEP || state_reg == DS_SLP_DLY))
    begin
      miso_reg   <= DEVICE_ID[id_idx_reg];
      id_idx_reg <= id_idx_reg - 3'h1;     // wraps, so the id repeats
    end
  end

  assign LINK.miso = miso_reg;

  // decode of the finished frame
  assign addr_ok      = (bcnt_reg == BITS_ADDRED);
  assign op_ok        = (bcnt_reg == BITS_OPCODE);
  assign is_addr_wipe = (op_reg == OP_UNIT4K_WIPE) || (op_reg == OP_HALF_WIPE) || (op_reg == OP_FULL_WIPE);
  assign is_chip_wipe = (op_reg == OP_CHIP_WIPE_A) || (op_reg == OP_CHIP_WIPE_B);

  // region and duration per opcode
  always_comb
  begin
    mask = MASK_ALL;
    dur  = 20'(CHIP_CYC);
    case (op_reg)
      OP_UNIT4K_WIPE:
      begin
        mask = MASK_4K;
        dur  = 20'(UNIT4K_CYC);
      end
      OP_HALF_WIPE:
      begin
        mask = MASK_32K;
        dur  = 20'(HALF_CYC_E);
      end
      OP_FULL_WIPE:
      begin
        mask = MASK_64K;
        dur  = 20'(FULL_CYC);
      end
      default:
      begin
        mask = MASK_ALL;
        dur  = 20'(CHIP_CYC);
      end
    endcase
  end

  // mode sequencer; reset value is standby, never sleep
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg    <= DS_STANDBY;
      tmr_reg      <= 20'h00000;
      unlock_reg   <= 1'b0;
      wipe_stb_reg <= 1'b0;
      wipe_lo_reg  <= 24'h000000;
      wipe_hi_reg  <= 24'h000000;
    end
    else
    begin
      wipe_stb_reg <= 1'b0;
      case (state_reg)
        DS_STANDBY:
        begin
          if (sel_rise)
          begin
            if (op_ok && op_reg == OP_WRITE_UNLOCK)
              unlock_reg <= 1'b1;
            else if (unlock_reg && addr_ok && is_addr_wipe
                     && !is_protected(addr_reg | mask, PROT_I))
            begin
              state_reg    <= DS_ERASE;
              tmr_reg      <= dur;
              unlock_reg   <= 1'b0;
              wipe_stb_reg <= 1'b1;
              wipe_lo_reg  <= addr_reg & ~mask;
              wipe_hi_reg  <= addr_reg | mask;
            end
            else if (unlock_reg && op_ok && is_chip_wipe && PROT_I == 4'h0)
            begin
              state_reg    <= DS_ERASE;
              tmr_reg      <= dur;
              unlock_reg   <= 1'b0;
              wipe_stb_reg <= 1'b1;
              wipe_lo_reg  <= 24'h000000;
              wipe_hi_reg  <= MASK_ALL;
            end
            else if (op_ok && op_reg == OP_SLEEP)
            begin
              state_reg <= DS_SLP_DLY;
              tmr_reg   <= 20'(SLEEP_CYC);
            end
            // a wake/id frame outside sleep leaves the state in standby, with no wake delay
          end
        end
        DS_ERASE:
        begin
          // frames during the cycle are not decoded at all
          if (tmr_reg <= 20'h00001)
            state_reg <= DS_STANDBY;
          tmr_reg <= tmr_reg - 20'h00001;
        end
        DS_SLP_DLY, DS_SLEEP:
        begin
          if (state_reg == DS_SLP_DLY)
          begin
            tmr_reg <= tmr_reg - 20'h00001;
            if (tmr_reg <= 20'h00001)
              state_reg <= DS_SLEEP;
          end
          // only the wake frame is honoured here
          if (sel_rise && op_reg == OP_WAKE_ID && (op_ok || bcnt_reg >= BITS_ADDRED))
          begin
            state_reg <= DS_WAKE;
            tmr_reg   <= op_ok ? 20'(WAKE_CYC) : 20'(WAKE_ID_CYC);
          end
        end
        DS_WAKE:
        begin
          if (tmr_reg <= 20'h00001)
            state_reg <= DS_STANDBY;
          tmr_reg <= tmr_reg - 20'h00001;
        end
        default:
          state_reg <= DS_STANDBY;
      endcase
    end
  end

  // status outputs, all from flops
  assign BUSY_O     = (state_reg == DS_ERASE);
  assign UNLOCK_O   = unlock_reg;
  assign SLEEP_O    = (state_reg == DS_SLEEP);
  assign STANDBY_O  = (state_reg == DS_STANDBY) && !sel_low;
  assign WIPE_STB_O = wipe_stb_reg;
  assign WIPE_LO_O  = wipe_lo_reg;
  assign WIPE_HI_O  = wipe_hi_reg;

endmodule
`default_nettype wire

// ===== rtl/sfe_flash_host.sv
// host end: shifts one command frame per software order, mode 0
// assumes the serial data input is asynchronous and synchronises it;
// the serial clock is made here by a divider of CLK_I
`timescale 1ns/1ns
`default_nettype none
module sfe_flash_host
  #(
    parameter int GAP_CYC = sfe_pkg::WAKE_CYC + sfe_pkg::SYNC_SLACK_CYC
  )
  (
    // clock and reset
    input  wire logic         CLK_I,
    input  wire logic         RST_N_I,
    // serial link
    sfe_link_if.host          LINK,
    // software register port
    input  wire logic [1:0]   REG_ADDR_I,
    input  wire logic [31:0]  REG_WDATA_I,
    input  wire logic         REG_WR_I,
    input  wire logic         REG_RD_I,
    output logic [31:0]       REG_RDATA_O
  );
  import sfe_pkg::*;

  sfe_host_state_t state_reg;
  logic [23:0]     addr_reg;
  logic [31:0]     tx_reg;
  logic [5:0]      bits_left_reg;
  logic [7:0]      hcnt_reg;
  logic            sclk_reg;
  logic            sel_n_reg;
  logic [1:0]      miso_sync_reg;
  logic [7:0]      rx_reg;
  logic [31:0]     rdata_reg;
  logic            go;

  assign go = REG_WR_I && REG_ADDR_I == REG_CMD && state_reg == HS_IDLE;

  // miso passes two flops before use
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      miso_sync_reg <= 2'h0;
    else
      miso_sync_reg <= {miso_sync_reg[0], LINK.miso};
  end

  // address register
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      addr_reg <= 24'h000000;
    else if (REG_WR_I && REG_ADDR_I == REG_ADDR)
      addr_reg <= REG_WDATA_I[23:0];
  end

  // frame sequencer; software orders unlock before erase
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg     <= HS_IDLE;
      tx_reg        <= 32'h00000000;
      bits_left_reg <= 6'h00;
      hcnt_reg      <= 8'h00;
      sclk_reg      <= 1'b0;
      sel_n_reg     <= 1'b1;
      rx_reg        <= RESET_ID;
    end
    else
    begin
      case (state_reg)
        HS_IDLE:
        begin
          if (go)
          begin
            state_reg     <= HS_SHIFT;
            sel_n_reg     <= 1'b0;
            tx_reg        <= {REG_WDATA_I[7:0], addr_reg};
            // opcode, then 0..3 address/dummy bytes, then 0 or 1 read byte
            bits_left_reg <= 6'(8 + 8 * REG_WDATA_I[9:8] + (REG_WDATA_I[10] ? 8 : 0));
            hcnt_reg      <= 8'(HALF_CYC - 1);
          end
        end
        HS_SHIFT:
        begin
          if (hcnt_reg != 8'h00)
            hcnt_reg <= hcnt_reg - 8'h01;
          else
          begin
            hcnt_reg <= 8'(HALF_CYC - 1);
            sclk_reg <= ~sclk_reg;
            if (sclk_reg)
            begin
              // falling edge: sample returned bit, advance or finish
              rx_reg        <= {rx_reg[6:0], miso_sync_reg[1]};
              tx_reg        <= {tx_reg[30:0], 1'b0};
              bits_left_reg <= bits_left_reg - 6'h01;
              if (bits_left_reg == 6'h01)
              begin
                state_reg <= HS_GAP;
                sel_n_reg <= 1'b1;
                hcnt_reg  <= 8'(GAP_CYC);
              end
            end
          end
        end
        HS_GAP:
        begin
          // deselect held long enough for wake delays
          if (hcnt_reg == 8'h00)
            state_reg <= HS_IDLE;
          else
            hcnt_reg <= hcnt_reg - 8'h01;
        end
        default:
          state_reg <= HS_IDLE;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rdata_reg <= 32'h00000000;
    else if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        REG_ADDR:   rdata_reg <= {8'h00, addr_reg};
        REG_STATUS: rdata_reg <= {16'h0000, rx_reg, 7'h00, state_reg != HS_IDLE};
        default:    rdata_reg <= 32'h00000000;
      endcase
    end
    else
      rdata_reg <= 32'h00000000;
  end

  assign REG_RDATA_O = rdata_reg;
  assign LINK.sel_n  = sel_n_reg;
  assign LINK.sclk   = sclk_reg;
  assign LINK.mosi   = tx_reg[31];

endmodule
`default_nettype wire

// ===== verif/sfe_props.sv
// checker: link pins and device status of the flash link
// assumes one instance beside the link interface, all in CLK_I domain
`timescale 1ns/1ns
`default_nettype none
module sfe_props
  import sfe_pkg::*;
  (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // link signals
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    // device status
    input wire logic WIPE_STB_O,
    input wire logic BUSY_O,
    input wire logic UNLOCK_O,
    input wire logic SLEEP_O,
    input wire logic STANDBY_O
  );
  int unsigned hi_cnt_reg;

  // cycles since select went high, saturating so it never wraps
  always_ff @(posedge CLK_I or negedge RST_N_I)
    if (!RST_N_I)
      hi_cnt_reg <= 0;
    else if (!sel_n)
      hi_cnt_reg <= 0;
    else if (hi_cnt_reg < 1000)
      hi_cnt_reg <= hi_cnt_reg + 1;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_sclk_idle: assert property (sel_n |-> !sclk)
    else $error("serial clock high while deselected");
  a_wipe_busy: assert property (WIPE_STB_O |-> BUSY_O && sel_n)
    else $error("erase strobe without busy or while selected");
  a_wipe_unlock: assert property (WIPE_STB_O |-> !UNLOCK_O && $past(UNLOCK_O))
    else $error("erase started without unlock latch");
  a_busy_start: assert property ($rose(BUSY_O) |-> WIPE_STB_O)
    else $error("busy rose without erase strobe");
  a_busy_bound: assert property ($rose(BUSY_O) |-> BUSY_O[*8] ##[1:1000] !BUSY_O)
    else $error("busy span out of range");
  a_sleep_idle: assert property (SLEEP_O |-> !BUSY_O && !WIPE_STB_O)
    else $error("sleep while erase active");
  a_sleep_standby: assert property (SLEEP_O |-> !STANDBY_O)
    else $error("standby reported during sleep");
  a_sleep_delay: assert property ($rose(SLEEP_O) |-> hi_cnt_reg inside {[SLEEP_CYC:SLEEP_CYC + 8]})
    else $error("sleep entered at wrong time");
  a_unlock_rise: assert property ($rose(UNLOCK_O) |-> sel_n && !BUSY_O && !SLEEP_O)
    else $error("unlock set at wrong moment");
  // data only moves on the falling serial edge, so it is steady while the clock is high
  a_mosi_steady: assert property (sclk |-> $stable(mosi))
    else $error("host data changed while serial clock high");
  // id output stops once the synchronised deselect reaches the device
  a_miso_quiet: assert property (sel_n && $past(sel_n, 3) |-> !miso)
    else $error("device data active while deselected");

  c_wipe: cover property (WIPE_STB_O);
  c_sleep: cover property ($rose(SLEEP_O));
  c_wake: cover property ($fell(SLEEP_O));
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// bench: host end and flash device end joined by the link interface
// assumes package, interface and both ends are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sfe_pkg::*;
  localparam int T4K = 20;
  localparam int T32 = 24;
  localparam int T64 = 28;
  localparam int TCH = 1000;  // long so frames fit inside one erase
  localparam logic [7:0] DEV_ID = 8'h3c;  // arbitrary value
  logic clk, rst_n, reg_wr, reg_rd, wipe_stb, busy, unlock, sleep, standby;
  logic [1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv, sh;
  logic [3:0] prot;
  logic [23:0] wipe_lo, wipe_hi;
  logic [7:0] ops [5] = '{OP_UNIT4K_WIPE, OP_HALF_WIPE, OP_FULL_WIPE, OP_CHIP_WIPE_A, OP_CHIP_WIPE_B};
  int mismatches, comparisons, nb, wipes, blen, bcnt, w0, seed;
  bit ulk;
  sfe_link_if lnk();

  sfe_flash_host i_sfe_flash_host (.CLK_I(clk), .RST_N_I(rst_n), .LINK(lnk), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata));
  sfe_flash_dev #(.UNIT4K_CYC(T4K), .HALF_CYC_E(T32), .FULL_CYC(T64), .CHIP_CYC(TCH), .DEVICE_ID(DEV_ID))
    i_sfe_flash_dev (.CLK_I(clk), .RST_N_I(rst_n), .LINK(lnk), .PROT_I(prot), .WIPE_STB_O(wipe_stb),
    .WIPE_LO_O(wipe_lo), .WIPE_HI_O(wipe_hi), .BUSY_O(busy), .UNLOCK_O(unlock), .SLEEP_O(sleep),
    .STANDBY_O(standby));
  sfe_props i_sfe_props (.CLK_I(clk), .RST_N_I(rst_n), .sel_n(lnk.sel_n), .sclk(lnk.sclk), .mosi(lnk.mosi),
    .miso(lnk.miso), .WIPE_STB_O(wipe_stb), .BUSY_O(busy), .UNLOCK_O(unlock), .SLEEP_O(sleep),
    .STANDBY_O(standby));

  // 25 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // erase strobes and busy spans as the device reports them
  always @(posedge clk)
  begin
    if (wipe_stb === 1'b1)
      wipes++;
    if (busy === 1'b1)
      bcnt++;
    else if (bcnt != 0)
    begin
      blen = bcnt;
      bcnt = 0;
    end
  end

  // bits on the wire, taken at serial clock rise while selected
  always @(negedge lnk.sel_n) nb = 0;
  always @(posedge lnk.sclk)
    if (!lnk.sel_n)
    begin
      sh = {sh[30:0], lnk.mosi};
      nb++;
    end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // register port: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // one frame, then poll until the host is idle again
  task automatic cmd(input logic [7:0] op, input int ex, input bit rb, input logic [23:0] a);
    int n;
    wr(REG_ADDR, {8'h00, a});
    wr(REG_CMD, {21'h0, rb, ex[1:0], op});
    n = 0;
    rv = 32'h1;
    while (rv[0] !== 1'b0 && n < 3000)
    begin
      rd(REG_STATUS);
      n++;
    end
    chk(rv[0], 0);
    chk(nb, 8 * (1 + ex + rb));
    if (!rb)
      chk((sh >> (nb - 8)) & 32'hff, op);
  endtask

  function automatic logic [23:0] span(input logic [7:0] op);
    case (op)
      OP_UNIT4K_WIPE: return MASK_4K;
      OP_HALF_WIPE: return MASK_32K;
      OP_FULL_WIPE: return MASK_64K;
      default: return MASK_ALL;
    endcase
  endfunction
  function automatic int dur(input logic [7:0] op);
    case (op)
      OP_UNIT4K_WIPE: return T4K;
      OP_HALF_WIPE: return T32;
      OP_FULL_WIPE: return T64;
      default: return TCH;
    endcase
  endfunction

  // one erase attempt; bad sends a wrong byte count, mid sends frames while busy
  task automatic erase_case(input logic [7:0] op, input logic [23:0] a, input logic [3:0] p,
                            input bit ul, input bit bad, input bit mid);
    int ex;
    logic [23:0] m;
    logic [23:0] hi;
    bit go;
    ex = (op == OP_CHIP_WIPE_A || op == OP_CHIP_WIPE_B) ? 0 : 3;
    m = span(op);
    hi = a | m;
    @(posedge clk);
    prot <= p;
    if (ul)
      cmd(OP_WRITE_UNLOCK, 0, 0, 24'h0);
    ulk = ulk || ul;
    chk(unlock, ulk);
    go = ulk && !bad && (ex == 0 ? p == 0 : (p == 0 || hi[23:20] < 16 - p));
    w0 = wipes;
    cmd(op, bad ? ex ^ 1 : ex, 0, a);
    if (mid)
    begin
      cmd(OP_SLEEP, 0, 0, 24'h0);
      cmd(OP_WAKE_ID, 0, 0, 24'h0);
      chk(busy, 1);
      chk(sleep, 0);
    end
    for (int n = 0; n < 1200 && busy !== 1'b0; n++)
      @(posedge clk);
    @(negedge clk);
    chk(wipes - w0, go);
    ulk = ulk && !go;
    chk(unlock, ulk);
    if (go)
    begin
      chk(wipe_lo, a & ~m);
      chk(wipe_hi, hi);
      chk(blen, dur(op));
    end
  endtask

  // main sequence
  initial
  begin
    seed = 32'hdf7e;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 32'h0;
    prot = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(sleep, 0);
    chk(standby, 1);
    rd(2'h3);
    chk(rv, 0);
    erase_case(OP_UNIT4K_WIPE, 24'h00ffff, 4'h0, 1, 0, 0);
    erase_case(OP_FULL_WIPE, 24'hf00000, 4'h1, 1, 0, 0);
    erase_case(OP_FULL_WIPE, 24'hefffff, 4'h1, 0, 0, 0);
    erase_case(OP_CHIP_WIPE_A, 24'h0, 4'h8, 1, 0, 0);
    for (int i = 0; i < 20; i++)
      erase_case(ops[i % 5], 24'($random(seed)), ($random(seed) & 1) ? 4'h0 : 4'($random(seed)),
                 ($random(seed) % 5) != 0, ($random(seed) % 6) == 0, 0);
    erase_case(OP_CHIP_WIPE_B, 24'h0, 4'h0, 1, 0, 1);
    // sleep: erase ignored, wake only, then wake with id
    cmd(OP_WRITE_UNLOCK, 0, 0, 24'h0);
    cmd(OP_SLEEP, 1, 0, 24'h0);
    chk(sleep, 0);
    cmd(OP_SLEEP, 0, 0, 24'h0);
    repeat (10) @(posedge clk);
    chk(sleep, 1);
    w0 = wipes;
    cmd(OP_UNIT4K_WIPE, 3, 0, 24'h001000);
    chk(wipes - w0, 0);
    chk(sleep, 1);
    cmd(OP_WAKE_ID, 0, 0, 24'h0);
    chk(sleep, 0);
    chk(standby, 1);
    cmd(OP_SLEEP, 0, 0, 24'h0);
    repeat (10) @(posedge clk);
    cmd(OP_WAKE_ID, 3, 1, 24'h0);
    rd(REG_STATUS);
    chk(rv[15:8], DEV_ID);
    chk(sleep, 0);
    cmd(OP_WAKE_ID, 3, 1, 24'h0);
    rd(REG_STATUS);
    chk(rv[15:8], DEV_ID);
    // reset while asleep comes back in standby
    cmd(OP_SLEEP, 0, 0, 24'h0);
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(sleep, 0);
    chk(standby, 1);
    print_verdict();
  end

  // watchdog, about 100000 clock cycles
  initial
  begin
    #4000000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
